// ==== core/swl_pkg.sv ====
// Package for the single-wire humidity/temperature link, device side.
// Assumes a 40 MHz system clock; printed times are in microseconds, derived counts in cycles.
package swl_pkg;
	localparam int CLK_MHZ = 40;
	// Printed times, microseconds
	localparam int T_START_MIN_US = 800;
	localparam int T_START_MAX_US = 20000;
	localparam int T_WAIT_US = 20;
	localparam int T_RESP_LOW_US = 80;
	localparam int T_RESP_HIGH_US = 80;
	localparam int T_BIT_LOW_US = 50;
	localparam int T_H0_US = 26;
	localparam int T_H1_US = 70;
	localparam int T_END_US = 50;
	// Cycle counts derived from the rate
	localparam int C_START_MIN = T_START_MIN_US * CLK_MHZ;
	localparam int C_START_MAX = T_START_MAX_US * CLK_MHZ;
	localparam int C_WAIT = T_WAIT_US * CLK_MHZ;
	localparam int C_RESP_LOW = T_RESP_LOW_US * CLK_MHZ;
	localparam int C_RESP_HIGH = T_RESP_HIGH_US * CLK_MHZ;
	localparam int C_BIT_LOW = T_BIT_LOW_US * CLK_MHZ;
	localparam int C_H0 = T_H0_US * CLK_MHZ;
	localparam int C_H1 = T_H1_US * CLK_MHZ;
	localparam int C_END = T_END_US * CLK_MHZ;
	localparam int CNT_W = 20;
	localparam int FRAME_BITS = 40;
	localparam int BIT_IDX_W = 6;
	localparam int SAMPLE_W = 32;
	localparam int FIFO_DEPTH = 4;
	localparam logic [15:0] HUM_RESET = 16'h0000;
	localparam logic [15:0] TEMP_RESET = 16'h0000;

	typedef enum logic [2:0] {
		SWL_IDLE = 3'h0,
		SWL_HOSTLOW = 3'h1,
		SWL_WAIT = 3'h3,
		SWL_RESPLOW = 3'h2,
		SWL_RESPHIGH = 3'h6,
		SWL_BITLOW = 3'h7,
		SWL_BITHIGH = 3'h5,
		SWL_ENDLOW = 3'h4
	} swl_state_t;
endpackage

// ==== core/swl_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain and a clock enable shared with the user.
`timescale 1ns/1ps
module swl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic push, pop;

	// ----------------------------------------
	// Pointer and count update
	// ----------------------------------------
	assign in_ready = (cnt_reg != FULL_CNT);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// Storage carries no reset; only control state does
	always_ff @(posedge clk_sys) begin
		if (clk_en && push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (clk_en) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ==== core/swl_device.sv ====
// Device end of the single-wire humidity/temperature readout link.
// Assumes an external pull-up on the line and a host keeping its start timing.
// Behaviour
// - Device sends exactly forty bits per request, MSB first.
// - Humidity is 16-bit unsigned, ten times percent, high byte first.
// - Last byte is the sum of the four data bytes.
// - Each read returns the measurement held before the current request.
// - Nobody drives the line high; only pull low or release.
// - Device transmits only after a valid start, silent otherwise.
// - Each bit is 50 us low, then 26 us high (0) or 70 us (1).
// - Device waits 20 us after release before responding.
// - After last bit device holds low 50 us, releases, sleeps.
`timescale 1ns/1ps
module swl_device #(
	parameter int START_MIN_CYC = swl_pkg::C_START_MIN,
	parameter int START_MAX_CYC = swl_pkg::C_START_MAX,
	parameter int CYC_PER_US = swl_pkg::CLK_MHZ,
	parameter int FIFO_DEPTH = swl_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	input wire logic [15:0] meas_hum,
	input wire logic [15:0] meas_temp,
	input wire logic meas_valid,
	output logic meas_ready,
	output logic frame_busy
);
	localparam logic [swl_pkg::CNT_W-1:0] START_MIN = swl_pkg::CNT_W'(START_MIN_CYC);
	localparam logic [swl_pkg::CNT_W-1:0] START_MAX = swl_pkg::CNT_W'(START_MAX_CYC);
	// Phase lengths scale with the cycle rate so a fast model can shrink them
	localparam logic [swl_pkg::CNT_W-1:0] WAIT_C =
		swl_pkg::CNT_W'(swl_pkg::T_WAIT_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] RLOW_C =
		swl_pkg::CNT_W'(swl_pkg::T_RESP_LOW_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] RHIGH_C =
		swl_pkg::CNT_W'(swl_pkg::T_RESP_HIGH_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] BLOW_C =
		swl_pkg::CNT_W'(swl_pkg::T_BIT_LOW_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] H0_C =
		swl_pkg::CNT_W'(swl_pkg::T_H0_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] H1_C =
		swl_pkg::CNT_W'(swl_pkg::T_H1_US * CYC_PER_US);
	localparam logic [swl_pkg::CNT_W-1:0] END_C =
		swl_pkg::CNT_W'(swl_pkg::T_END_US * CYC_PER_US);
	localparam logic [swl_pkg::BIT_IDX_W-1:0] LAST_BIT =
		swl_pkg::BIT_IDX_W'(swl_pkg::FRAME_BITS - 1);

	// ----------------------------------------
	// Line input synchroniser
	// ----------------------------------------
	logic sync1_reg, sync2_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else if (clk_en) begin
			sync1_reg <= line_in;
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// Measurement buffer
	// ----------------------------------------
	logic [swl_pkg::SAMPLE_W-1:0] fifo_data;
	logic fifo_valid, fifo_pop, fifo_in_ready;

	swl_fifo #(
		.WIDTH(swl_pkg::SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_data({meas_hum, meas_temp}),
		.in_valid(meas_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ----------------------------------------
	// Transaction state machine
	// ----------------------------------------
	swl_pkg::swl_state_t state_reg, state_next;
	logic [swl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [swl_pkg::BIT_IDX_W-1:0] bit_reg, bit_next;
	logic [swl_pkg::FRAME_BITS-1:0] shift_reg, shift_next;
	logic [15:0] hum_reg, hum_next, temp_reg, temp_next;
	logic drive_low_reg, drive_low_next;
	logic echo1_reg, echo2_reg;
	logic ready_reg, ready_next;
	logic busy_reg, busy_next;
	logic [7:0] csum;
	logic [swl_pkg::CNT_W-1:0] cnt_inc;

	// Modulo-256 sum of the four data bytes
	assign csum = hum_reg[15:8] + hum_reg[7:0] + temp_reg[15:8] + temp_reg[7:0];
	assign cnt_inc = cnt_reg + 1'b1;
	// Drain only between frames so the frame shows one stable sample
	assign fifo_pop = (state_reg == swl_pkg::SWL_IDLE) && fifo_valid;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_inc;
		bit_next = bit_reg;
		shift_next = shift_reg;
		hum_next = hum_reg;
		temp_next = temp_reg;
		drive_low_next = 1'b0;
		busy_next = 1'b1;
		ready_next = fifo_in_ready;
		case (state_reg)
			swl_pkg::SWL_IDLE: begin
				busy_next = 1'b0;
				cnt_next = '0;
				if (fifo_pop) begin
					hum_next = fifo_data[31:16];
					temp_next = fifo_data[15:0];
				end
				if (!sync2_reg && !echo1_reg && !echo2_reg) begin
					state_next = swl_pkg::SWL_HOSTLOW;
				end
			end
			swl_pkg::SWL_HOSTLOW: begin
				// Saturate so an endless low stays rejected
				if (cnt_reg == START_MAX) begin
					cnt_next = cnt_reg;
				end
				if (sync2_reg) begin
					cnt_next = '0;
					// Too short or too long a pulse gets no answer
					if (cnt_reg >= START_MIN && cnt_reg < START_MAX) begin
						state_next = swl_pkg::SWL_WAIT;
					end else begin
						state_next = swl_pkg::SWL_IDLE;
					end
				end
			end
			swl_pkg::SWL_WAIT: begin
				if (cnt_inc == WAIT_C) begin
					cnt_next = '0;
					state_next = swl_pkg::SWL_RESPLOW;
					drive_low_next = 1'b1;
					// Frame fixed here from the sample held before the request
					shift_next = {hum_reg, temp_reg, csum};
				end
			end
			swl_pkg::SWL_RESPLOW: begin
				drive_low_next = 1'b1;
				if (cnt_inc == RLOW_C) begin
					cnt_next = '0;
					drive_low_next = 1'b0;
					state_next = swl_pkg::SWL_RESPHIGH;
				end
			end
			swl_pkg::SWL_RESPHIGH: begin
				if (cnt_inc == RHIGH_C) begin
					cnt_next = '0;
					bit_next = '0;
					drive_low_next = 1'b1;
					state_next = swl_pkg::SWL_BITLOW;
				end
			end
			swl_pkg::SWL_BITLOW: begin
				drive_low_next = 1'b1;
				if (cnt_inc == BLOW_C) begin
					cnt_next = '0;
					drive_low_next = 1'b0;
					state_next = swl_pkg::SWL_BITHIGH;
				end
			end
			swl_pkg::SWL_BITHIGH: begin
				// MSB of the shifter is the bit on the wire
				if (cnt_inc == (shift_reg[swl_pkg::FRAME_BITS-1] ? H1_C : H0_C)) begin
					cnt_next = '0;
					drive_low_next = 1'b1;
					shift_next = {shift_reg[swl_pkg::FRAME_BITS-2:0], 1'b0};
					bit_next = bit_reg + 1'b1;
					if (bit_reg == LAST_BIT) begin
						state_next = swl_pkg::SWL_ENDLOW;
					end else begin
						state_next = swl_pkg::SWL_BITLOW;
					end
				end
			end
			swl_pkg::SWL_ENDLOW: begin
				drive_low_next = 1'b1;
				if (cnt_inc == END_C) begin
					cnt_next = '0;
					drive_low_next = 1'b0;
					state_next = swl_pkg::SWL_IDLE;
				end
			end
			default: begin
				cnt_next = '0;
				state_next = swl_pkg::SWL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= swl_pkg::SWL_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			hum_reg <= swl_pkg::HUM_RESET;
			temp_reg <= swl_pkg::TEMP_RESET;
			drive_low_reg <= 1'b0;
			ready_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			hum_reg <= hum_next;
			temp_reg <= temp_next;
			drive_low_reg <= drive_low_next;
			ready_reg <= ready_next;
			busy_reg <= busy_next;
		end
	end

	// ----------------------------------------
	// Open-drain pin: value always low, enable pulls
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			line_out <= 1'b0;
		end else if (clk_en) begin
			line_out <= 1'b0;
		end
	end
	assign line_oe = drive_low_reg;

	// Own release shows high only two cycles later through the synchroniser;
	// masking that tail keeps the end pulse from reading as a host start
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			echo1_reg <= 1'b0;
			echo2_reg <= 1'b0;
		end else if (clk_en) begin
			echo1_reg <= drive_low_reg;
			echo2_reg <= echo1_reg;
		end
	end
	// Registered copy of the FIFO's room; one cycle late, so user must
	// treat it as advisory and the FIFO drops writes while full
	assign meas_ready = ready_reg;
	assign frame_busy = busy_reg;
endmodule

// ==== testbench/swl_device_sva.sv ====
// Assertions on the device end of the single-wire link.
// Assumes clk_en held high; the phase counters do not look at it.
`timescale 1ns/1ps
module swl_device_sva #(
	parameter int START_MIN_CYC = 40,
	parameter int START_MAX_CYC = 400,
	parameter int CYC_PER_US = swl_pkg::CLK_MHZ
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_oe,
	input wire logic [15:0] meas_hum,
	input wire logic [15:0] meas_temp,
	input wire logic meas_valid,
	input wire logic meas_ready,
	input wire logic frame_busy
);
	localparam int C_WAIT = swl_pkg::T_WAIT_US * CYC_PER_US;
	localparam int C_RLOW = swl_pkg::T_RESP_LOW_US * CYC_PER_US;
	localparam int C_RHIGH = swl_pkg::T_RESP_HIGH_US * CYC_PER_US;
	localparam int C_BLOW = swl_pkg::T_BIT_LOW_US * CYC_PER_US;
	localparam int C_H0 = swl_pkg::T_H0_US * CYC_PER_US;
	localparam int C_H1 = swl_pkg::T_H1_US * CYC_PER_US;
	localparam int C_END = swl_pkg::T_END_US * CYC_PER_US;
	int hi_cnt, lo_cnt, rises, in_hi;
	// ----------------
	// Phase counters
	// ----------------
	// Run lengths of pull-low, release and sensed high level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
			rises <= 0;
			in_hi <= 0;
		end else begin
			hi_cnt <= line_oe ? hi_cnt + 1 : 0;
			lo_cnt <= line_oe ? 0 : lo_cnt + 1;
			in_hi <= line_in ? in_hi + 1 : 0;
			rises <= frame_busy ? rises + int'($rose(line_oe)) : 0;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_first_drive;
		$rose(line_oe) && rises == 0;
	endsequence
	sequence s_idle_high;
		(!frame_busy && line_in)[*4];
	endsequence
	chk_never_high: assert property (line_out == 1'b0)
		else $error("line value driven high");
	chk_drive_in_frame: assert property (line_oe |-> frame_busy)
		else $error("line pulled low outside a frame");
	chk_drive_len: assert property ($fell(line_oe) |->
		hi_cnt == C_BLOW || hi_cnt == C_RLOW || hi_cnt == C_END)
		else $error("low phase length wrong");
	chk_release_len: assert property ($rose(line_oe) && rises != 0 |->
		lo_cnt inside {C_RHIGH, C_H0, C_H1})
		else $error("high phase length wrong");
	chk_resp_wait: assert property (s_first_drive |->
		in_hi >= C_WAIT && in_hi <= C_WAIT + 8)
		else $error("response wait wrong");
	chk_bit_count: assert property ($fell(frame_busy) |-> rises == 0 || rises == 42)
		else $error("pulse count in frame wrong");
	chk_idle_quiet: assert property (s_idle_high |=> !frame_busy)
		else $error("frame started without a start pulse");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !line_oe && !frame_busy && !meas_ready)
		else $error("outputs active after reset");
endmodule
bind swl_device swl_device_sva #(.START_MIN_CYC(START_MIN_CYC), .START_MAX_CYC(START_MAX_CYC),
	.CYC_PER_US(CYC_PER_US))
	i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .line_in(line_in),
	.line_out(line_out), .line_oe(line_oe), .meas_hum(meas_hum), .meas_temp(meas_temp),
	.meas_valid(meas_valid), .meas_ready(meas_ready), .frame_busy(frame_busy));

// ==== testbench/swl_host.sv ====
// Behavioural host for the single-wire link.
// Assumes the bench resolves the pulled-up line from both enables.
`timescale 1ns/1ps
module swl_host #(
	parameter int THRESH_CYC = 1920
) (
	input wire logic clk_sys,
	input wire logic line,
	output logic host_oe,
	output logic [39:0] bits,
	output int nbits
);
	int hi = 0;
	int nh = 0;
	initial host_oe = 1'b0;
	initial bits = 40'h0;
	initial nbits = 0;
	// ----------------
	// Start and decode
	// ----------------
	// Pull low for len cycles, then release only
	task automatic start(input int len);
		host_oe <= 1'b1;
		repeat (len) @(posedge clk_sys);
		host_oe <= 1'b0;
	endtask
	// First two highs are wait and response; later highs are bits
	always @(posedge clk_sys) begin
		if (host_oe) begin
			hi <= 0;
			nh <= 0;
			nbits <= 0;
		end else if (line) begin
			hi <= hi + 1;
		end else if (hi != 0) begin
			nh <= nh + 1;
			if (nh >= 2) begin
				bits <= {bits[38:0], hi > THRESH_CYC};
				nbits <= nbits + 1;
			end
			hi <= 0;
		end
	end
endmodule

// ==== testbench/single_wire_humidity_temp_link_tb.sv ====
// Bench for the device end of the single-wire link.
// Assumes shortened start limits of 40 and 400 cycles and 4 cycles per us.
`timescale 1ns/1ps
module single_wire_humidity_temp_link_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic meas_valid = 1'b0;
	logic [15:0] meas_hum = 16'h0000;
	logic [15:0] meas_temp = 16'h0000;
	logic line_oe, line_out, meas_ready, frame_busy, host_oe, line;
	logic [39:0] bits;
	int nbits;
	int n_mismatch = 0;
	int check_count = 0;
	// Compressed timebase keeps two full frames well inside the run budget
	localparam int CYC_PER_US = 4;
	// Pull-up: low whenever either side pulls
	assign line = !(host_oe || line_oe);
	swl_device #(.START_MIN_CYC(40), .START_MAX_CYC(400), .CYC_PER_US(CYC_PER_US))
		i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .clk_en(clk_en), .line_in(line), .line_out(line_out),
		.line_oe(line_oe), .meas_hum(meas_hum), .meas_temp(meas_temp),
		.meas_valid(meas_valid), .meas_ready(meas_ready), .frame_busy(frame_busy));
	swl_host #(.THRESH_CYC(48 * CYC_PER_US)) i_host (.clk_sys(clk_sys), .line(line),
		.host_oe(host_oe), .bits(bits),
		.nbits(nbits));
	initial forever #12.5 clk_sys = ~clk_sys;
	// ----------------
	// Helpers
	// ----------------
	task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait; a hung frame ends the run
	task automatic wait_idle();
		for (int i = 0; i < 40000; i++) begin
			@(posedge clk_sys);
			if (frame_busy === 1'b0) return;
		end
		n_mismatch++;
		stop_test();
	endtask
	// ----------------
	// Scenarios
	// ----------------
	// Too short and too long start pulses must get no answer
	task automatic t_bad_start();
		int lens[2] = '{20, 500};
		foreach (lens[k]) begin
			i_host.start(lens[k]);
			wait_idle();
			repeat (4000) @(posedge clk_sys);
			check("bad start bits", 40'h0, 40'(nbits));
		end
	endtask
	// Negative temperature, wrapping checksum, samples queued mid-frame
	task automatic t_frame();
		meas_hum <= 16'h0292;
		meas_temp <= 16'h8065;
		meas_valid <= 1'b1;
		@(posedge clk_sys);
		meas_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
		i_host.start(100);
		for (int k = 0; k < 4; k++) begin
			meas_hum <= 16'(k);
			meas_valid <= 1'b1;
			@(posedge clk_sys);
		end
		meas_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("ready when full", 40'h0, 40'(meas_ready));
		wait_idle();
		check("frame", {16'h0292, 16'h8065, 8'h79}, bits);
		check("bit count", 40'd40, 40'(nbits));
		repeat (20) @(posedge clk_sys);
		check("ready after drain", 40'h1, 40'(meas_ready));
	endtask
	// Second read returns the last sample queued during the first frame
	task automatic t_reread();
		repeat (200) @(posedge clk_sys);
		i_host.start(100);
		wait_idle();
		check("second frame", {16'h0003, 16'h8065, 8'he8}, bits);
		check("second bit count", 40'd40, 40'(nbits));
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_bad_start();
		t_frame();
		t_reread();
		stop_test();
	end
endmodule
